// *** shared/obm_pkg.sv ***
// Package: constants, register map and carrier types for the reverse/backup control block
package obm_pkg;
   // =====================================================================
   // Clock and timing
   localparam int CLK_FREQ_KHZ   = 250000;
   localparam int START_DLY_US   = 5000;
   localparam int START_DLY_CYC  = (START_DLY_US * CLK_FREQ_KHZ + 999) / 1000;
   localparam int INT_PULSE_NS   = 1000;
   localparam int INT_PULSE_CYC  = (INT_PULSE_NS * CLK_FREQ_KHZ + 999999) / 1000000;
   localparam int STRAP_WAIT_CYC = 3;

   // =====================================================================
   // Register indices (byte address is four times the index)
   localparam logic [5:0] IDX_CTRL   = 6'h00;
   localparam logic [5:0] IDX_VSET   = 6'h01;
   localparam logic [5:0] IDX_ISET   = 6'h02;
   localparam logic [5:0] IDX_CFG    = 6'h03;
   localparam logic [5:0] IDX_STAT   = 6'h04;
   localparam logic [5:0] IDX_FLAG   = 6'h05;
   localparam logic [5:0] IDX_RETURN = 6'h16;

   // CTRL fields
   localparam int CTRL_EN     = 0;
   localparam int CTRL_GATE1  = 1;
   localparam int CTRL_GATE2  = 2;
   localparam int CTRL_GDIS   = 3;
   localparam int CTRL_BKEN   = 4;
   localparam int CTRL_LLDIS  = 5;
   localparam int CTRL_AFDIS  = 6;
   // CFG fields
   localparam int CFG_DLIM_LSB = 0;
   localparam int CFG_TRIP_LSB = 2;
   localparam int CFG_OVP_LSB  = 4;
   localparam int CFG_DLIM_MSK = 6;
   localparam int CFG_PORT_MSK = 7;
   // FLAG fields
   localparam int FLAG_DLIM = 0;
   localparam int FLAG_PORT = 1;
   // RETURN field
   localparam int RET_BIT = 0;

   // Reset values
   localparam logic [10:0] VSET_RST = 11'h000;
   localparam logic [6:0]  ISET_RST = 7'h00;
   localparam logic [7:0]  CFG_RST  = 8'hC3;
   localparam logic [1:0]  DLIM_OFF = 2'h3;

   // Port state codes
   localparam logic [3:0] PORT_IDLE    = 4'h0;
   localparam logic [3:0] PORT_REVERSE = 4'h7;
   localparam logic [3:0] PORT_BACKUP  = 4'hC;

   // =====================================================================
   // Carrier types
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_DELAY = 2'b11,
      ST_RUN   = 2'b10
   } obm_state_type;

   typedef struct packed {
      logic batt_above_entry;
      logic battery_overvoltage;
      logic port_below_uvlo;
      logic therm_in_window;
      logic port_high;
      logic port_below_backup;
      logic input_overvoltage;
      logic batt_below_exit;
      logic discharge_over_limit;
      logic pair1_present;
      logic pair2_present;
   } obm_sense_type;

   typedef struct packed {
      logic        conv_run;
      logic        pair1_gate_on;
      logic        pair2_gate_on;
      logic        light_load_off;
      logic        audio_floor_off;
      logic        output_current_cut;
      logic        soft_start_en;
      logic        forward_charge_off;
      logic        skip_source_checks;
      logic        normal_powerup;
      logic        int_n;
      logic [10:0] voltage_setpoint;
      logic [6:0]  current_limit;
      logic [1:0]  discharge_limit_sel;
      logic [1:0]  trip_ratio;
      logic [1:0]  ovp_sel;
   } obm_drive_type;

   localparam obm_drive_type DRIVE_RST = '{int_n: 1'b1, discharge_limit_sel: DLIM_OFF, default: '0};
endpackage : obm_pkg

// *** core/obm_core.sv ***
// Reverse output / backup mode control with register port
//
// Overview of operation
// [R1] Reverse enable only with battery above entry level, no overvoltage, port low, thermistor ok.
// [R2] Output setpoint is an 11-bit field, output current limit a 7-bit field.
// [R3] No pair present or gates globally disabled: converter starts 5 ms after enable.
// [R4] One pair present: converter waits for that pair's gate enable.
// [R5] Both pairs present: converter waits for either gate enable.
// [R6] Clearing the active gate enable stops the converter; setting the other restarts it.
// [R7] Light-load and audio-floor disable bits act while in reverse mode.
// [R8] Discharge over limit: cut output current, set status, pulse interrupt, flag if unmasked.
// [R9] Limit codes 00..10 apply soft-start; 11 disables limit and soft-start.
// [R10] Backup enable set only while port high; cleared when port goes low.
// [R11] Armed and port below trip: stop charging, force enable, code 1100, interrupt, flag.
// [R12] Backup trip threshold chosen by a 2-bit ratio field.
// [R13] Host cannot set reverse enable while port high; only backup trigger can.
// [R14] Entering backup sets global gate disable.
// [R15] Input overvoltage turns off pair one and enters backup mode.
// [R16] Pair one absent at power-on holds backup enable at zero.
// [R17] Backup ends on low battery or host clearing reverse enable.
// [R18] Writing return bit clears gate disable, enables pair one, disarms backup.
// [R19] Clearing enable while return bit set clears it and re-arms backup.
// [R20] With return bit cleared first, clearing enable leaves backup disarmed.
// [R21] Clear with return bit skips source checks; otherwise normal power-up.
// [R22] Host should allow 5 s of settling before re-arming.
// [R23] Each interrupt is one fixed-length active-low pulse, regardless of masks; a new event during a pulse restarts and lengthens it.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module obm_core
   import obm_pkg::*;
#(
   parameter int START_DLY = START_DLY_CYC,
   parameter int INT_CYC   = INT_PULSE_CYC
) (
   input  wire logic          MCLK,
   input  wire logic          RST,
   input  wire logic [7:0]    ADDR,
   input  wire logic [31:0]   WDATA,
   input  wire logic          WR,
   input  wire logic          RD,
   output logic      [31:0]   RDATA,
   input  wire obm_sense_type SENSE,
   output obm_drive_type      DRIVE
);

   // ======================================================================
   // Input synchronisers and power-on strap capture
   obm_sense_type sense_m_r;
   obm_sense_type sense_r;
   logic [1:0]    strap_cnt_r;
   logic          p1_present_r;
   logic          p2_present_r;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sense_m_r <= '0;
         sense_r   <= '0;
      end else begin
         sense_m_r <= SENSE;
         sense_r   <= sense_m_r;
      end
   end

   // Straps are latched once the synchroniser has settled after reset
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         strap_cnt_r  <= 2'h0;
         p1_present_r <= 1'b0;
         p2_present_r <= 1'b0;
      end else if (strap_cnt_r != 2'(STRAP_WAIT_CYC)) begin
         strap_cnt_r <= strap_cnt_r + 2'h1;
         if (strap_cnt_r == 2'(STRAP_WAIT_CYC - 1)) begin
            p1_present_r <= sense_r.pair1_present;
            p2_present_r <= sense_r.pair2_present;
         end
      end
   end

   // ======================================================================
   // Bus decode
   logic       hit;
   logic [5:0] idx;
   logic       wr_ctrl;
   logic       wr_ret;

   assign idx     = ADDR[7:2];
   assign hit     = (ADDR[1:0] == 2'h0);
   assign wr_ctrl = WR && hit && (idx == IDX_CTRL);
   assign wr_ret  = WR && hit && (idx == IDX_RETURN);

   // ======================================================================
   // Control register and backup sequencing
   logic en_r;
   logic gate1_r;
   logic gate2_r;
   logic gdis_r;
   logic bk_en_r;
   logic lldis_r;
   logic afdis_r;
   logic ret_r;
   logic bk_act_r;
   logic skip_r;
   logic normal_r;
   logic allowed;
   logic trig;
   logic host_set_en;
   logic host_clr_en;
   logic [7:0] cfg_r;

   assign allowed = sense_r.batt_above_entry && !sense_r.battery_overvoltage
                 && sense_r.port_below_uvlo && sense_r.therm_in_window;                      // R1
   assign trig    = bk_en_r && !bk_act_r
                 && (sense_r.port_below_backup || sense_r.input_overvoltage);               // R11 R15
   assign host_set_en = wr_ctrl && WDATA[CTRL_EN] && !en_r && allowed && !sense_r.port_high; // R13
   assign host_clr_en = wr_ctrl && !WDATA[CTRL_EN] && en_r;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         en_r     <= 1'b0;
         gate1_r  <= 1'b0;
         gate2_r  <= 1'b0;
         gdis_r   <= 1'b0;
         bk_en_r  <= 1'b0;
         lldis_r  <= 1'b0;
         afdis_r  <= 1'b0;
         ret_r    <= 1'b0;
         bk_act_r <= 1'b0;
         skip_r   <= 1'b0;
         normal_r <= 1'b0;
      end else begin
         skip_r   <= 1'b0;
         normal_r <= 1'b0;
         if (wr_ctrl) begin
            gate1_r <= WDATA[CTRL_GATE1];
            gate2_r <= WDATA[CTRL_GATE2];
            gdis_r  <= WDATA[CTRL_GDIS];
            lldis_r <= WDATA[CTRL_LLDIS];
            afdis_r <= WDATA[CTRL_AFDIS];
            if (!WDATA[CTRL_BKEN])
               bk_en_r <= 1'b0;
            else if (sense_r.port_high)                                                     // R10
               bk_en_r <= 1'b1;
         end
         if (host_set_en)
            en_r <= 1'b1;
         if (wr_ret)
            ret_r <= WDATA[RET_BIT];
         if (wr_ret && WDATA[RET_BIT]) begin
            gdis_r   <= 1'b0;                                                               // R18
            gate1_r  <= 1'b1;                                                               // R18
            bk_en_r  <= 1'b0;                                                               // R18
            bk_act_r <= 1'b0;
         end
         if (host_clr_en) begin
            en_r     <= 1'b0;                                                               // R17
            bk_act_r <= 1'b0;
            if (ret_r) begin
               ret_r   <= 1'b0;                                                             // R19
               bk_en_r <= 1'b1;                                                             // R19
               skip_r  <= 1'b1;                                                             // R21
            end else begin
               normal_r <= 1'b1;                                                            // R20 R21
            end
         end
         if (bk_act_r && sense_r.batt_below_exit) begin
            bk_act_r <= 1'b0;                                                               // R17
            en_r     <= 1'b0;
         end
         // Battery or thermistor loss drops plain reverse mode; the port is ours to raise, so not watched
         if (en_r && !bk_act_r && !host_set_en
             && !(sense_r.batt_above_entry && !sense_r.battery_overvoltage && sense_r.therm_in_window))
            en_r <= 1'b0;
         if (trig) begin
            en_r     <= 1'b1;                                                               // R11
            gdis_r   <= 1'b1;                                                               // R14 R15
            bk_act_r <= 1'b1;
            bk_en_r  <= 1'b0;
         end else if (!sense_r.port_high && !bk_act_r)
            bk_en_r <= 1'b0;                                                                // R10
         if (!p1_present_r)
            bk_en_r <= 1'b0;                                                                // R16
      end
   end

   // ======================================================================
   // Setpoints and configuration
   logic [10:0] vset_r;
   logic [6:0]  iset_r;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         vset_r <= VSET_RST;
         iset_r <= ISET_RST;
         cfg_r  <= CFG_RST;
      end else if (WR && hit) begin
         if (idx == IDX_VSET)
            vset_r <= WDATA[10:0];                                                          // R2
         if (idx == IDX_ISET)
            iset_r <= WDATA[6:0];                                                           // R2
         if (idx == IDX_CFG)
            cfg_r <= WDATA[7:0];
      end
   end

   // ======================================================================
   // Converter start gating
   obm_state_type st_r;
   logic [31:0]   dly_cnt_r;
   logic          direct;
   logic          gate_ok;

   assign direct  = gdis_r || (!p1_present_r && !p2_present_r);                             // R3
   assign gate_ok = (p1_present_r && gate1_r) || (p2_present_r && gate2_r);                 // R4 R5

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         st_r      <= ST_IDLE;
         dly_cnt_r <= '0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               dly_cnt_r <= '0;
               if (en_r)
                  st_r <= direct ? ST_DELAY : ST_WAIT;
            end
            ST_WAIT: begin
               if (!en_r)
                  st_r <= ST_IDLE;
               else if (direct)
                  st_r <= ST_DELAY;
               else if (gate_ok)
                  st_r <= ST_RUN;                                                           // R4 R5
            end
            ST_DELAY: begin
               dly_cnt_r <= dly_cnt_r + 32'h1;
               if (!en_r)
                  st_r <= ST_IDLE;
               else if (dly_cnt_r == 32'(START_DLY - 1))
                  st_r <= ST_RUN;                                                           // R3
            end
            ST_RUN: begin
               if (!en_r)
                  st_r <= ST_IDLE;
               else if (!direct && !gate_ok)
                  st_r <= ST_WAIT;                                                          // R6
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // ======================================================================
   // Discharge limit, event flags and interrupt pulse
   logic       dlim_act_r;
   logic       dlim_rise;
   logic       bk_rise;
   logic       bk_act_d_r;
   logic [1:0] flag_r;
   logic [31:0] int_cnt_r;
   logic       flag_clr_d;
   logic       flag_clr_p;

   assign dlim_rise  = sense_r.discharge_over_limit && (st_r == ST_RUN)
                    && (cfg_r[CFG_DLIM_LSB +: 2] != DLIM_OFF) && !dlim_act_r;               // R8 R9
   assign bk_rise    = bk_act_r && !bk_act_d_r;
   assign flag_clr_d = WR && hit && (idx == IDX_FLAG) && WDATA[FLAG_DLIM];
   assign flag_clr_p = WR && hit && (idx == IDX_FLAG) && WDATA[FLAG_PORT];

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         dlim_act_r <= 1'b0;
         bk_act_d_r <= 1'b0;
      end else begin
         bk_act_d_r <= bk_act_r;
         dlim_act_r <= sense_r.discharge_over_limit && (st_r == ST_RUN)
                    && (cfg_r[CFG_DLIM_LSB +: 2] != DLIM_OFF);                               // R8
      end
   end

   // Set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         flag_r <= 2'h0;
      end else begin
         if (dlim_rise && !cfg_r[CFG_DLIM_MSK])
            flag_r[FLAG_DLIM] <= 1'b1;                                                      // R8
         else if (flag_clr_d)
            flag_r[FLAG_DLIM] <= 1'b0;
         if (bk_rise && !cfg_r[CFG_PORT_MSK])
            flag_r[FLAG_PORT] <= 1'b1;                                                      // R11
         else if (flag_clr_p)
            flag_r[FLAG_PORT] <= 1'b0;
      end
   end

   // A new event during a pulse restarts it, so pulses never merge short
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST)
         int_cnt_r <= '0;
      else if (dlim_rise || bk_rise)
         int_cnt_r <= 32'(INT_CYC);                                                         // R23
      else if (int_cnt_r != 32'h0)
         int_cnt_r <= int_cnt_r - 32'h1;
   end

   // ======================================================================
   // Registered outputs
   logic [3:0] port_code;

   assign port_code = bk_act_r ? PORT_BACKUP : (en_r ? PORT_REVERSE : PORT_IDLE);           // R11

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         DRIVE <= DRIVE_RST;
      end else begin
         DRIVE.conv_run            <= (st_r == ST_RUN);
         DRIVE.pair1_gate_on       <= gate1_r && p1_present_r && !gdis_r;                   // R14 R15
         DRIVE.pair2_gate_on       <= gate2_r && p2_present_r && !gdis_r;
         DRIVE.light_load_off      <= en_r && lldis_r;                                      // R7
         DRIVE.audio_floor_off     <= en_r && afdis_r;                                      // R7
         DRIVE.output_current_cut  <= dlim_act_r;                                           // R8
         DRIVE.soft_start_en       <= (cfg_r[CFG_DLIM_LSB +: 2] != DLIM_OFF);               // R9
         DRIVE.forward_charge_off  <= en_r;                                                 // R11
         DRIVE.skip_source_checks  <= skip_r;                                               // R21
         DRIVE.normal_powerup      <= normal_r;                                             // R21
         DRIVE.int_n               <= (int_cnt_r == 32'h0);                                 // R23
         DRIVE.voltage_setpoint    <= vset_r;
         DRIVE.current_limit       <= iset_r;
         DRIVE.discharge_limit_sel <= cfg_r[CFG_DLIM_LSB +: 2];
         DRIVE.trip_ratio          <= cfg_r[CFG_TRIP_LSB +: 2];                             // R12
         DRIVE.ovp_sel             <= cfg_r[CFG_OVP_LSB +: 2];                              // R15
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         RDATA <= 32'h0;
      end else if (RD && hit) begin
         case (idx)
            IDX_CTRL:   RDATA <= {25'h0, afdis_r, lldis_r, bk_en_r, gdis_r, gate2_r, gate1_r, en_r};
            IDX_VSET:   RDATA <= {21'h0, vset_r};
            IDX_ISET:   RDATA <= {25'h0, iset_r};
            IDX_CFG:    RDATA <= {24'h0, cfg_r};
            IDX_STAT:   RDATA <= {23'h0, bk_act_r, (st_r == ST_RUN), p2_present_r, p1_present_r,
                                  dlim_act_r, port_code};
            IDX_FLAG:   RDATA <= {30'h0, flag_r};
            IDX_RETURN: RDATA <= {31'h0, ret_r};
            default:    RDATA <= 32'h0;
         endcase
      end else begin
         RDATA <= 32'h0;
      end
   end

   // ======================================================================
   // Assertions
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   sequence s_return_write;
      wr_ret && WDATA[RET_BIT];
   endsequence

   sequence s_clear_with_return;
      host_clr_en && ret_r && !trig;
   endsequence

   a_host_set_blocked: assert property (wr_ctrl && WDATA[CTRL_EN] && !en_r && sense_r.port_high && !trig // R13
      |=> !en_r) else $error("reverse enable set while port high");
   a_start_delay: assert property (st_r == ST_DELAY && en_r && dly_cnt_r < 32'(START_DLY - 1) // R3
      |=> st_r != ST_RUN) else $error("converter started before delay");
   a_wait_gate: assert property (st_r == ST_WAIT && !gate_ok // R4
      |=> st_r != ST_RUN) else $error("converter started without gate enable");
   a_gate_drop_stop: assert property (st_r == ST_RUN && en_r && !direct && !gate_ok // R6
      |=> st_r == ST_WAIT) else $error("converter kept running after gate drop");
   a_backup_entry: assert property (trig |=> en_r && gdis_r && bk_act_r ##1 DRIVE.forward_charge_off // R11
      ) else $error("backup entry incomplete");
   a_backup_int: assert property (bk_rise |=> ##1 !DRIVE.int_n [*2]) else $error("no interrupt on backup"); // R23
   a_arm_drop: assert property (!sense_r.port_high && !trig && !bk_act_r && !host_clr_en // R10
      |=> !bk_en_r) else $error("backup enable kept with port low");
   a_no_pair1: assert property (strap_cnt_r == 2'(STRAP_WAIT_CYC) && !p1_present_r // R16
      |=> !bk_en_r) else $error("backup armed without pair one");
   a_return_req: assert property (s_return_write ##0 !trig |=> !gdis_r && gate1_r && !bk_en_r) // R18
      else $error("return request not applied");
   a_rearm: assert property (s_clear_with_return |=> bk_en_r && !ret_r ##1 DRIVE.skip_source_checks) // R19
      else $error("re-arm sequence failed");
   a_low_batt_exit: assert property (bk_act_r && sense_r.batt_below_exit && !trig // R17
      |=> !bk_act_r && !en_r) else $error("backup not left on low battery");
   a_dlim_flag: assert property (dlim_rise && !cfg_r[CFG_DLIM_MSK] |=> flag_r[FLAG_DLIM] ##1 !DRIVE.int_n) // R8
      else $error("discharge event not flagged");
endmodule : obm_core

// *** bench/obm_port_model.sv ***
// Far-side model: port rail held by an adapter or by the converter
`timescale 1ns/10ps
module obm_port_model
   import obm_pkg::*;
(
   input  wire logic          MCLK,
   input  wire logic          ADAPTER,
   input  wire logic          CONV_RUN,
   input  wire obm_sense_type BASE,
   output obm_sense_type      SENSE
);
   logic port_r = 1'b0;
   // =====================================
   // Rail collapses one cycle after both sources let go
   always_ff @(posedge MCLK) begin
      port_r <= ADAPTER | CONV_RUN;
   end
   always_comb begin
      SENSE                   = BASE;
      SENSE.port_high         = port_r;
      SENSE.port_below_uvlo   = !port_r;
      SENSE.port_below_backup = !port_r;
   end
endmodule : obm_port_model

// *** bench/test_otg_backup_mode_control.sv ***
// Self-checking bench for the reverse/backup control block
`timescale 1ns/10ps
module test_otg_backup_mode_control
   import obm_pkg::*;
;
   localparam int SD = 20;
   localparam int IC = 4;
   logic MCLK = 0, RST = 1, WR = 0, RD = 0, adapter = 1;
   logic [7:0] ADDR = '0;
   logic [31:0] WDATA = '0, RDATA, d, seed = 32'h35;
   obm_sense_type base = '0, sense;
   obm_drive_type drive;
   int failures = 0, n_tests = 0, n;
   always #2 MCLK = ~MCLK;
   obm_core #(.START_DLY(SD), .INT_CYC(IC)) dut_u (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .SENSE(sense), .DRIVE(drive));
   obm_port_model port_u (.MCLK(MCLK), .ADAPTER(adapter), .CONV_RUN(drive.conv_run), .BASE(base),
      .SENSE(sense));
   // =====================================
   // Helpers
   function logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task finish_test();
      $display("mismatches %0d of %0d checks", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   task wr(input logic [5:0] i, input logic [31:0] v);
      @(posedge MCLK);
      ADDR <= {i, 2'b00};
      WDATA <= v;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask : wr
   task rd(input logic [5:0] i);
      @(posedge MCLK);
      ADDR <= {i, 2'b00};
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask : rd
   // Reads until the masked value matches, bounded
   task poll(input logic [5:0] i, input logic [31:0] m, input logic [31:0] e);
      for (int k = 0; k < 200; k++) begin
         rd(i);
         if ((d & m) === e) break;
      end
      d = d & m;
      if (d !== e) begin
         failures++;
         finish_test();
      end
   endtask : poll
   task run_wait(input logic e);
      for (n = 0; n < 200 && drive.conv_run !== e; n++) @(posedge MCLK);
      if (n == 200) begin
         failures++;
         finish_test();
      end
   endtask : run_wait
   task pulse(output int c);
      int k;
      c = 0;
      for (k = 0; k < 60 && drive.int_n !== 1'b0; k++) @(posedge MCLK);
      for (k = 0; k < 60 && drive.int_n === 1'b0; k++) begin
         @(posedge MCLK);
         c++;
      end
      if (c == 0 || k == 60) begin
         failures++;
         finish_test();
      end
   endtask : pulse
   task reset(input logic p1);
      RST <= 1'b1;
      base.pair1_present <= p1;
      repeat (12) @(posedge MCLK);
      RST <= 1'b0;
      repeat (4) @(posedge MCLK);
   endtask : reset
   // =====================================
   // Main sequence
   initial begin
      base.therm_in_window = 1'b1;
      reset(1'b0);
      rd(IDX_CFG); check(d, 32'h000000C3);
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         wr(IDX_VSET, seed);
         rd(IDX_VSET); check(d, {21'h0, seed[10:0]});
         check(drive.voltage_setpoint, seed[10:0]);
         wr(IDX_ISET, seed >> 8);
         rd(IDX_ISET); check(d, {25'h0, seed[14:8]});
         check(drive.current_limit, seed[14:8]);
      end
      for (int s = 0; s < 4; s++) begin
         wr(IDX_CFG, 32'hC0 | (seed & 32'h3C) | s);
         rd(IDX_CFG);
         check(drive.soft_start_en, s != 3);
         check({drive.ovp_sel, drive.trip_ratio, drive.discharge_limit_sel}, {seed[5:2], 2'(s)});
      end
      base.batt_above_entry <= 1'b1;
      wr(IDX_CTRL, 32'h11);
      rd(IDX_CTRL); check(d, 32'h0);
      base.batt_above_entry <= 1'b0;
      adapter <= 1'b0;
      repeat (5) @(posedge MCLK);
      wr(IDX_CTRL, 32'h1);
      rd(IDX_CTRL); check(d, 32'h0);
      base.batt_above_entry <= 1'b1;
      repeat (5) @(posedge MCLK);
      wr(IDX_CTRL, 32'h61);
      run_wait(1'b1);
      check(n >= SD && n <= SD + 4, 1'b1);
      check({drive.light_load_off, drive.audio_floor_off}, 2'b11);
      wr(IDX_CFG, 32'hC0);
      base.discharge_over_limit <= 1'b1;
      pulse(n); check(n, IC);
      rd(IDX_STAT); check(d[4], 1'b1);
      check({drive.output_current_cut, drive.soft_start_en}, 2'b11);
      rd(IDX_FLAG); check(d[0], 1'b0);
      base.discharge_over_limit <= 1'b0;
      wr(IDX_CFG, 32'h80);
      repeat (5) @(posedge MCLK);
      base.discharge_over_limit <= 1'b1;
      pulse(n); check(n, IC);
      rd(IDX_FLAG); check(d[0], 1'b1);
      base.discharge_over_limit <= 1'b0;
      reset(1'b1);
      wr(IDX_CTRL, 32'h1);
      repeat (SD + 8) @(posedge MCLK);
      check(drive.conv_run, 1'b0);
      wr(IDX_CTRL, 32'h7);
      run_wait(1'b1); check({drive.pair2_gate_on, drive.pair1_gate_on}, 2'b01);
      wr(IDX_CTRL, 32'h1);
      run_wait(1'b0); check(drive.conv_run, 1'b0);
      wr(IDX_CTRL, 32'h0);
      @(posedge MCLK); #1 check(drive.normal_powerup, 1'b1);
      adapter <= 1'b1;
      repeat (5) @(posedge MCLK);
      wr(IDX_CTRL, 32'h10);
      rd(IDX_CTRL); check(d, 32'h10);
      adapter <= 1'b0;
      pulse(n); check(n, IC);
      poll(IDX_CTRL, 32'h19, 32'h09); check(d, 32'h09);
      rd(IDX_STAT); check(d[3:0], PORT_BACKUP);
      adapter <= 1'b1;
      wr(IDX_RETURN, 32'h1);
      poll(IDX_CTRL, 32'h1B, 32'h03); check(d, 32'h03);
      wr(IDX_CTRL, 32'h2);
      @(posedge MCLK); #1 check(drive.skip_source_checks, 1'b1);
      poll(IDX_CTRL, 32'h11, 32'h10); check(d, 32'h10);
      rd(IDX_RETURN); check(d, 32'h0);
      adapter <= 1'b0;
      pulse(n); check(n, IC);
      adapter <= 1'b1;
      wr(IDX_RETURN, 32'h1);
      poll(IDX_CTRL, 32'h3, 32'h3); check(d, 32'h3);
      wr(IDX_RETURN, 32'h0);
      wr(IDX_CTRL, 32'h2);
      @(posedge MCLK); #1 check(drive.normal_powerup, 1'b1);
      poll(IDX_CTRL, 32'h11, 32'h0); check(d, 32'h0);
      wr(IDX_CTRL, 32'h10);
      adapter <= 1'b0;
      pulse(n); check(n, IC);
      rd(IDX_STAT); check(d[8], 1'b1);
      base.batt_below_exit <= 1'b1;
      poll(IDX_STAT, 32'h100, 32'h0); check(d, 32'h0);
      rd(IDX_CTRL); check(d[0], 1'b0);
      finish_test();
   end
endmodule : test_otg_backup_mode_control
